// [snscmd_regs.sv]
`timescale 1ns/10ps
// Notes on behaviour
// - type 00 keeps the register address fixed across data bytes
// - type 01 advances the register address after each data byte
// - type 11 makes the low five bits a special-function code
// - types 00 and 01 latch bits 4:0 as the target address
// - code 00000 does nothing; 00101, 00110, 00111 clear prox, light, both
// - interrupt clear removes the pending flag and needs no follow-up write
// - with sleep_after_irq set, power down at end of an interrupting cycle
// - proximity interrupts only while prox_irq_mask is set
// - light interrupts only while light_irq_mask is set
// - wait-enable bit turns the wait timer on and off
// - prox_function_enable turns proximity measurement on and off
// - light_function_enable turns the two-channel light converter on and off
// - oscillator_power_bit runs the oscillator; timers run only while it runs
// - light integration steps are 256 minus the light time value
// - proximity integration steps are counted the same way
// - first write byte after the address is the command byte only with bit 7 set, else data; rest data
// - a read without a new command uses the held register address
// - answer only slave address 0x39
// - reset: function_enable 0x00, both time registers 0xff
module snscmd_regs #(
   parameter int STEP_CYCLES = snscmd_pkg::STEP_CYCLES_DEF
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic link_clk_i,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   input wire logic prox_event_i,
   input wire logic light_event_i,
   input wire logic cycle_end_i,
   output logic osc_run_o,
   output logic step_tick_o,
   output logic wait_enable_o,
   output logic prox_enable_o,
   output logic light_enable_o,
   output logic [8:0] light_steps_o,
   output logic [8:0] prox_steps_o,
   output logic [15:0] light_max_count_o,
   output logic prox_irq_o,
   output logic light_irq_o,
   output logic prox_clr_o,
   output logic light_clr_o
);

   localparam int STEP_W = $clog2(STEP_CYCLES + 1);

   typedef enum logic [2:0] {
      L_IDLE = 3'b000,
      L_ADDR = 3'b001,
      L_ADDR_ACK = 3'b010,
      L_WBYTE = 3'b011,
      L_WACK = 3'b100,
      L_RWAIT = 3'b101,
      L_RBYTE = 3'b110,
      L_RACK = 3'b111
   } snscmd_link_state_type;

   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic scl_s1;
      logic scl_s2;
      logic scl_prev;
      logic sda_s1;
      logic sda_s2;
      logic sda_prev;
      snscmd_link_state_type st;
      logic [7:0] shift;
      logic [3:0] cnt;
      logic rnw;
      logic first;
      logic more;
      logic sda_drv;
      logic scl_hold;
      logic ready;
      logic req_tgl;
      snscmd_pkg::snscmd_req_type req_kind;
      logic [7:0] req_data;
      logic ans_s1;
      logic ans_s2;
      logic ans_prev;
   } snscmd_link_type;

   typedef struct packed {
      logic [7:0] func_en;
      logic [7:0] light_time;
      logic [7:0] prox_time;
      logic [4:0] addr;
      snscmd_pkg::snscmd_xfer_type xtype;
      logic req_s1;
      logic req_s2;
      logic req_prev;
      logic ans_tgl;
      logic [7:0] ans_data;
      logic prox_irq;
      logic light_irq;
      logic cycle_irq;
      logic prox_clr;
      logic light_clr;
      logic [STEP_W-1:0] step_cnt;
      logic step_tick;
   } snscmd_core_type;

   localparam snscmd_link_type LINK_RST = '0;
   localparam snscmd_core_type CORE_RST = '{
      func_en: snscmd_pkg::FUNC_EN_RST,
      light_time: snscmd_pkg::TIME_RST,
      prox_time: snscmd_pkg::TIME_RST,
      xtype: snscmd_pkg::XFER_REPEAT,
      default: '0
   };

   function automatic logic [8:0] steps_fn(input logic [7:0] t);
      return snscmd_pkg::STEPS_FULL - {1'b0, t};
   endfunction

   function automatic logic [15:0] max_count_fn(input logic [8:0] s);
      if (s >= snscmd_pkg::LIGHT_SAT_STEPS)
      begin
         return snscmd_pkg::COUNT_SAT;
      end
      return {s[5:0], 10'h000} - 16'h0001;
   endfunction

   snscmd_link_type lq, ld;
   snscmd_core_type cq, cd;

   // link side: oversampled serial slave, stretches the clock on reads
   logic scl_rise, scl_fall, bus_start, bus_stop, ans_evt;

   always_comb
   begin
      scl_rise = lq.scl_s2 & ~lq.scl_prev;
      scl_fall = ~lq.scl_s2 & lq.scl_prev;
      bus_start = lq.scl_s2 & lq.scl_prev & lq.sda_prev & ~lq.sda_s2;
      bus_stop = lq.scl_s2 & lq.scl_prev & ~lq.sda_prev & lq.sda_s2;
      ans_evt = lq.ans_s2 ^ lq.ans_prev;
      ld = lq;
      ld.scl_s1 = scl_i;
      ld.scl_s2 = lq.scl_s1;
      ld.scl_prev = lq.scl_s2;
      ld.sda_s1 = sda_i;
      ld.sda_s2 = lq.sda_s1;
      ld.sda_prev = lq.sda_s2;
      ld.ans_s1 = cq.ans_tgl;
      ld.ans_s2 = lq.ans_s1;
      ld.ans_prev = lq.ans_s2;
      if ((lq.st == L_ADDR || lq.st == L_WBYTE) && scl_rise)
      begin
         ld.shift = {lq.shift[6:0], lq.sda_s2};
         ld.cnt = lq.cnt + 4'h1;
      end
      unique case (lq.st)
         L_IDLE:
         begin
         end
         L_ADDR:
         begin
            if (scl_fall && lq.cnt == snscmd_pkg::BYTE_BITS)
            begin
               if (lq.shift[7:1] == snscmd_pkg::DEV_ADDR)
               begin
                  ld.sda_drv = 1'b1;
                  ld.rnw = lq.shift[0];
                  ld.st = L_ADDR_ACK;
               end
               else
               begin
                  ld.st = L_IDLE;
               end
            end
         end
         L_ADDR_ACK:
         begin
            if (scl_fall)
            begin
               ld.sda_drv = 1'b0;
               ld.cnt = 4'h0;
               if (lq.rnw)
               begin
                  // read uses the held address
                  ld.req_kind = snscmd_pkg::REQ_RD;
                  ld.req_tgl = ~lq.req_tgl;
                  ld.scl_hold = 1'b1;
                  ld.ready = 1'b0;
                  ld.st = L_RWAIT;
               end
               else
               begin
                  ld.first = 1'b1;
                  ld.st = L_WBYTE;
               end
            end
         end
         L_WBYTE:
         begin
            if (scl_fall && lq.cnt == snscmd_pkg::BYTE_BITS)
            begin
               ld.req_kind = lq.first ? snscmd_pkg::REQ_CMD
                                      : snscmd_pkg::REQ_WR;
               ld.req_data = lq.shift;
               ld.req_tgl = ~lq.req_tgl;
               ld.sda_drv = 1'b1;
               ld.st = L_WACK;
            end
         end
         L_WACK:
         begin
            if (scl_fall)
            begin
               ld.sda_drv = 1'b0;
               ld.cnt = 4'h0;
               ld.first = 1'b0;
               ld.st = L_WBYTE;
            end
         end
         L_RWAIT:
         begin
            // data goes on the line one cycle before the clock is let go
            if (lq.ready)
            begin
               ld.scl_hold = 1'b0;
               ld.cnt = 4'h0;
               ld.st = L_RBYTE;
            end
            else if (ans_evt)
            begin
               ld.shift = cq.ans_data;
               ld.sda_drv = ~cq.ans_data[7];
               ld.ready = 1'b1;
            end
         end
         L_RBYTE:
         begin
            if (scl_fall)
            begin
               ld.cnt = lq.cnt + 4'h1;
               if (lq.cnt == snscmd_pkg::LAST_TX_BIT)
               begin
                  ld.sda_drv = 1'b0;
                  ld.st = L_RACK;
               end
               else
               begin
                  ld.shift = {lq.shift[6:0], 1'b0};
                  ld.sda_drv = ~lq.shift[6];
               end
            end
         end
         L_RACK:
         begin
            if (scl_rise)
            begin
               ld.more = ~lq.sda_s2;
            end
            if (scl_fall)
            begin
               if (lq.more)
               begin
                  ld.req_kind = snscmd_pkg::REQ_RD;
                  ld.req_tgl = ~lq.req_tgl;
                  ld.scl_hold = 1'b1;
                  ld.ready = 1'b0;
                  ld.st = L_RWAIT;
               end
               else
               begin
                  ld.st = L_IDLE;
               end
            end
         end
      endcase
      if (bus_start)
      begin
         ld.st = L_ADDR;
         ld.cnt = 4'h0;
         ld.sda_drv = 1'b0;
         ld.scl_hold = 1'b0;
      end
      else if (bus_stop)
      begin
         ld.st = L_IDLE;
         ld.sda_drv = 1'b0;
         ld.scl_hold = 1'b0;
      end
      ld.rst_s1 = rst_n_i;
      ld.rst_s2 = lq.rst_s1;
      if (!lq.rst_s2)
      begin
         ld = LINK_RST;
         ld.rst_s1 = rst_n_i;
         ld.rst_s2 = lq.rst_s1;
      end
   end

   always_ff @(posedge link_clk_i)
   begin
      lq <= ld;
   end

   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_n_o = ~lq.scl_hold;
   assign sda_oe_n_o = ~lq.sda_drv;

   // core side: register file and command decode
   logic req_evt, is_cmd, wr_en, rd_en, sf_en;
   logic [7:0] rq_data;
   logic [7:0] rd_byte;
   logic prox_set, light_set;

   always_comb
   begin
      req_evt = cq.req_s2 ^ cq.req_prev;
      rq_data = lq.req_data;
      is_cmd = req_evt && lq.req_kind == snscmd_pkg::REQ_CMD
               && rq_data[snscmd_pkg::CMD_SEL_BIT];
      // a first byte without the select bit is data at the held address
      wr_en = req_evt && (lq.req_kind == snscmd_pkg::REQ_WR
              || (lq.req_kind == snscmd_pkg::REQ_CMD
              && !rq_data[snscmd_pkg::CMD_SEL_BIT]));
      rd_en = req_evt && lq.req_kind == snscmd_pkg::REQ_RD;
      sf_en = is_cmd && rq_data[snscmd_pkg::TYPE_HI:snscmd_pkg::TYPE_LO]
              == snscmd_pkg::XFER_SPECIAL;
      unique case (cq.addr)
         snscmd_pkg::FUNC_EN_OFS: rd_byte = cq.func_en;
         snscmd_pkg::LIGHT_TIME_OFS: rd_byte = cq.light_time;
         snscmd_pkg::PROX_TIME_OFS: rd_byte = cq.prox_time;
         default: rd_byte = 8'h00;
      endcase
      prox_set = prox_event_i
                 & cq.func_en[snscmd_pkg::PROX_IRQ_MASK_BIT];
      light_set = light_event_i
                  & cq.func_en[snscmd_pkg::LIGHT_IRQ_MASK_BIT];
      cd = cq;
      cd.req_s1 = lq.req_tgl;
      cd.req_s2 = cq.req_s1;
      cd.req_prev = cq.req_s2;
      cd.prox_clr = 1'b0;
      cd.light_clr = 1'b0;
      if (is_cmd && !sf_en && rq_data[snscmd_pkg::TYPE_HI:snscmd_pkg::TYPE_LO]
          != snscmd_pkg::XFER_RSVD)
      begin
         cd.addr = rq_data[snscmd_pkg::CODE_HI:0];
         cd.xtype = snscmd_pkg::snscmd_xfer_type'(
            rq_data[snscmd_pkg::TYPE_HI:snscmd_pkg::TYPE_LO]);
      end
      if (sf_en)
      begin
         unique case (rq_data[snscmd_pkg::CODE_HI:0])
            snscmd_pkg::SF_PROX_CLR: cd.prox_clr = 1'b1;
            snscmd_pkg::SF_LIGHT_CLR: cd.light_clr = 1'b1;
            snscmd_pkg::SF_BOTH_CLR:
            begin
               cd.prox_clr = 1'b1;
               cd.light_clr = 1'b1;
            end
            default:
            begin
            end
         endcase
      end
      if (wr_en)
      begin
         unique case (cq.addr)
            snscmd_pkg::FUNC_EN_OFS:
            begin
               cd.func_en = rq_data;
               cd.func_en[snscmd_pkg::RSVD_BIT] = 1'b0;
            end
            snscmd_pkg::LIGHT_TIME_OFS: cd.light_time = rq_data;
            snscmd_pkg::PROX_TIME_OFS: cd.prox_time = rq_data;
            default:
            begin
            end
         endcase
      end
      if (rd_en)
      begin
         cd.ans_data = rd_byte;
         cd.ans_tgl = ~cq.ans_tgl;
      end
      if ((wr_en || rd_en) && cq.xtype == snscmd_pkg::XFER_AUTO_INC)
      begin
         cd.addr = cq.addr + 5'h01;
      end
      // clear first so that an event in the same cycle survives
      if (cd.prox_clr)
      begin
         cd.prox_irq = 1'b0;
      end
      if (cd.light_clr)
      begin
         cd.light_irq = 1'b0;
      end
      if (prox_set)
      begin
         cd.prox_irq = 1'b1;
      end
      if (light_set)
      begin
         cd.light_irq = 1'b1;
      end
      cd.cycle_irq = cq.cycle_irq | prox_set | light_set;
      if (cycle_end_i)
      begin
         cd.cycle_irq = 1'b0;
         if ((cq.cycle_irq || prox_set || light_set)
             && cq.func_en[snscmd_pkg::SLEEP_AFTER_IRQ_BIT])
         begin
            cd.func_en[snscmd_pkg::OSC_POWER_BIT] = 1'b0;
         end
      end
      // step timebase only runs with the oscillator powered
      cd.step_tick = 1'b0;
      if (!cq.func_en[snscmd_pkg::OSC_POWER_BIT])
      begin
         cd.step_cnt = '0;
      end
      else if (cq.step_cnt == STEP_W'(STEP_CYCLES - 1))
      begin
         cd.step_cnt = '0;
         cd.step_tick = 1'b1;
      end
      else
      begin
         cd.step_cnt = cq.step_cnt + STEP_W'(1);
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      cq <= rst_n_i ? cd : CORE_RST;
   end

   assign osc_run_o = cq.func_en[snscmd_pkg::OSC_POWER_BIT];
   assign step_tick_o = cq.step_tick;
   assign wait_enable_o = osc_run_o
                          & cq.func_en[snscmd_pkg::WAIT_EN_BIT];
   assign prox_enable_o = osc_run_o
                          & cq.func_en[snscmd_pkg::PROX_FUNC_EN_BIT];
   assign light_enable_o = osc_run_o
                           & cq.func_en[snscmd_pkg::LIGHT_FUNC_EN_BIT];
   assign light_steps_o = steps_fn(cq.light_time);
   assign prox_steps_o = steps_fn(cq.prox_time);
   assign light_max_count_o = max_count_fn(light_steps_o);
   assign prox_irq_o = cq.prox_irq;
   assign light_irq_o = cq.light_irq;
   assign prox_clr_o = cq.prox_clr;
   assign light_clr_o = cq.light_clr;

   logic [4:0] cmd_code;
   assign cmd_code = rq_data[snscmd_pkg::CODE_HI:0];

   sequence s_cmd_set_addr;
      is_cmd && !sf_en && rq_data[6:5] != snscmd_pkg::XFER_RSVD;
   endsequence

   sequence s_prox_clear;
      sf_en && (cmd_code == snscmd_pkg::SF_PROX_CLR
                || cmd_code == snscmd_pkg::SF_BOTH_CLR) && !prox_event_i;
   endsequence

   property p_reset_values;
      @(posedge core_clk_i) !rst_n_i |=> cq.func_en == 8'h00
         && cq.light_time == 8'hff && cq.prox_time == 8'hff;
   endproperty
   a_reset_values: assert property (p_reset_values)
      else $error("register reset values wrong");

   property p_latch_addr;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         s_cmd_set_addr |=> cq.addr == $past(cmd_code);
   endproperty
   a_latch_addr: assert property (p_latch_addr)
      else $error("command byte address not latched");

   property p_auto_inc;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         (wr_en || rd_en) && cq.xtype == snscmd_pkg::XFER_AUTO_INC
         |=> cq.addr == $past(cq.addr) + 5'h01;
   endproperty
   a_auto_inc: assert property (p_auto_inc)
      else $error("auto-increment did not advance address");

   property p_repeat_hold;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         (wr_en || rd_en) && cq.xtype == snscmd_pkg::XFER_REPEAT
         |=> $stable(cq.addr);
   endproperty
   a_repeat_hold: assert property (p_repeat_hold)
      else $error("repeated-byte access moved address");

   property p_special_no_addr;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         sf_en |=> $stable(cq.addr) && $stable(cq.xtype);
   endproperty
   a_special_no_addr: assert property (p_special_no_addr)
      else $error("special function changed address");

   property p_prox_clear;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         s_prox_clear |=> prox_clr_o && !prox_irq_o ##1 !prox_clr_o;
   endproperty
   a_prox_clear: assert property (p_prox_clear)
      else $error("proximity clear did not take effect");

   property p_prox_masked;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         !cq.func_en[5] && !prox_irq_o |=> !prox_irq_o;
   endproperty
   a_prox_masked: assert property (p_prox_masked)
      else $error("proximity interrupt raised while masked");

   property p_light_masked;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         !cq.func_en[4] && !light_irq_o |=> !light_irq_o;
   endproperty
   a_light_masked: assert property (p_light_masked)
      else $error("light interrupt raised while masked");

   property p_sleep_after;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         cycle_end_i && cq.cycle_irq && cq.func_en[6] |=> !osc_run_o;
   endproperty
   a_sleep_after: assert property (p_sleep_after)
      else $error("no power down after interrupting cycle");

   property p_max_count;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         cq.light_time == 8'hff |-> light_max_count_o == 16'h03ff
         && light_steps_o == 9'h001;
   endproperty
   a_max_count: assert property (p_max_count)
      else $error("light full-scale wrong for one step");

   property p_first_is_cmd;
      @(posedge link_clk_i) disable iff (!lq.rst_s2)
         lq.st == L_WBYTE && lq.first && scl_fall && lq.cnt == 4'h8
         |=> lq.req_kind == snscmd_pkg::REQ_CMD && lq.st == L_WACK;
   endproperty
   a_first_is_cmd: assert property (p_first_is_cmd)
      else $error("first write byte not taken as command");

   property p_addr_match;
      @(posedge link_clk_i) disable iff (!lq.rst_s2)
         lq.st == L_ADDR && scl_fall && lq.cnt == 4'h8
         && lq.shift[7:1] != 7'h39 |=> lq.st == L_IDLE && !lq.sda_drv;
   endproperty
   a_addr_match: assert property (p_addr_match)
      else $error("foreign slave address acknowledged");

endmodule

// [snscmd_pkg.sv]
package snscmd_pkg;

   // serial bus slave address, 7-bit
   localparam logic [6:0] DEV_ADDR = 7'h39;

   // register indices
   localparam logic [4:0] FUNC_EN_OFS = 5'h00;
   localparam logic [4:0] LIGHT_TIME_OFS = 5'h01;
   localparam logic [4:0] PROX_TIME_OFS = 5'h02;

   // reset values
   localparam logic [7:0] FUNC_EN_RST = 8'h00;
   localparam logic [7:0] TIME_RST = 8'hff;

   // function_enable fields
   localparam int RSVD_BIT = 7;
   localparam int SLEEP_AFTER_IRQ_BIT = 6;
   localparam int PROX_IRQ_MASK_BIT = 5;
   localparam int LIGHT_IRQ_MASK_BIT = 4;
   localparam int WAIT_EN_BIT = 3;
   localparam int PROX_FUNC_EN_BIT = 2;
   localparam int LIGHT_FUNC_EN_BIT = 1;
   localparam int OSC_POWER_BIT = 0;

   // command byte fields
   localparam int CMD_SEL_BIT = 7;
   localparam int TYPE_HI = 6;
   localparam int TYPE_LO = 5;
   localparam int CODE_HI = 4;

   typedef enum logic [1:0] {
      XFER_REPEAT = 2'b00,
      XFER_AUTO_INC = 2'b01,
      XFER_RSVD = 2'b10,
      XFER_SPECIAL = 2'b11
   } snscmd_xfer_type;

   // special-function codes
   localparam logic [4:0] SF_NONE = 5'h00;
   localparam logic [4:0] SF_PROX_CLR = 5'h05;
   localparam logic [4:0] SF_LIGHT_CLR = 5'h06;
   localparam logic [4:0] SF_BOTH_CLR = 5'h07;

   // byte requests passed from the link to the core
   typedef enum logic [1:0] {
      REQ_CMD = 2'b00,
      REQ_WR = 2'b01,
      REQ_RD = 2'b10
   } snscmd_req_type;

   // integration step timing
   localparam int STEP_TIME_NS = 2730000;
   localparam int CORE_CLK_NS = 10;
   localparam int STEP_CYCLES_DEF = STEP_TIME_NS / CORE_CLK_NS;
   localparam logic [8:0] STEPS_FULL = 9'h100;

   // light channel full-scale
   localparam logic [8:0] LIGHT_SAT_STEPS = 9'h040;
   localparam logic [15:0] COUNT_SAT = 16'hffff;

   // link bit counts: received bits that mark a whole byte, and the last bit index sent on reads
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] LAST_TX_BIT = 4'h7;

endpackage

// [snscmd_host.sv]
`timescale 1ns/10ps
// bus master model; the low phase stays long enough for the link sampler
// (at least 8 link clocks); only reads stretch the clock
module snscmd_host (
   input wire logic dev_scl_oe_n_i,
   input wire logic dev_sda_oe_n_i,
   output logic scl_o,
   output logic sda_o
);
   localparam int LOW_NS = 1300;
   localparam int HIGH_NS = 700;
   logic scl_m = 1'b1;
   logic sda_m = 1'b1;
   // pulled-up lines: whoever pulls low wins
   assign scl_o = scl_m & dev_scl_oe_n_i;
   assign sda_o = sda_m & dev_sda_oe_n_i;
   task automatic put_bit(input logic b, output logic seen);
      #(LOW_NS / 2);
      sda_m = b;
      #(LOW_NS / 2);
      scl_m = 1'b1;
      // a stretching slave keeps the line low; high phase starts at release
      wait (scl_o === 1'b1);
      #(HIGH_NS / 2);
      seen = sda_o;
      #(HIGH_NS / 2);
      scl_m = 1'b0;
   endtask
   // address byte, then command byte, then data bytes
   task automatic xfer(input logic [7:0] adr, input logic [23:0] d,
                       input int n, output int acks);
      logic s;
      logic [7:0] b;
      acks = 0;
      sda_m = 1'b0;
      #HIGH_NS;
      scl_m = 1'b0;
      for (int i = 0; i <= n; i++)
      begin
         b = (i == 0) ? adr : d[31 - 8 * i -: 8];
         for (int k = 7; k >= 0; k--)
            put_bit(b[k], s);
         put_bit(1'b1, s);
         acks += int'(s === 1'b0);
      end
      stop_bus();
   endtask
   task automatic stop_bus();
      #(LOW_NS / 2);
      sda_m = 1'b0;
      #(LOW_NS / 2);
      scl_m = 1'b1;
      #HIGH_NS;
      sda_m = 1'b1;
      #LOW_NS;
   endtask
   // address byte with the read bit, then n bytes, acked all but the last
   task automatic rd(input logic [7:0] adr, input int n,
                     output logic [23:0] got, output int acks);
      logic s;
      got = '0;
      sda_m = 1'b0;
      #HIGH_NS;
      scl_m = 1'b0;
      for (int k = 7; k >= 0; k--)
         put_bit(adr[k], s);
      put_bit(1'b1, s);
      acks = int'(s === 1'b0);
      for (int i = 0; i < n; i++)
      begin
         for (int k = 7; k >= 0; k--)
         begin
            put_bit(1'b1, s);
            got = {got[22:0], s};
         end
         put_bit(logic'(i == n - 1), s);
      end
      stop_bus();
   endtask
endmodule

// [sensor_command_enable_timing_regs_tb.sv]
`timescale 1ns/10ps
`define CHK(got, exp) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         fails++; \
         $display("unexpected at %0t: %h not %h", $time, got, exp); \
      end \
   end
module sensor_command_enable_timing_regs_tb;
   localparam int STEPS = 20;
   localparam logic [7:0] WA = {snscmd_pkg::DEV_ADDR, 1'b0};
   localparam logic [7:0] RA = {snscmd_pkg::DEV_ADDR, 1'b1};
   // set once the device has held the serial clock low
   logic held = 1'b0;
   logic core_clk_i = 1'b0;
   logic link_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic ev_p = 1'b0;
   logic ev_l = 1'b0;
   logic ev_c = 1'b0;
   logic scl, sda, scl_oe_n, sda_oe_n, osc_run, tick, wait_en, prox_en;
   logic light_en, prox_irq, light_irq;
   logic [8:0] light_steps, prox_steps;
   logic [15:0] max_count;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #5 core_clk_i = ~core_clk_i;
   initial
   begin
      #37;
      forever #80 link_clk_i = ~link_clk_i;
   end
   snscmd_regs #(.STEP_CYCLES(STEPS)) DUT (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i),
      .scl_i(scl), .scl_o(), .scl_oe_n_o(scl_oe_n), .sda_i(sda), .sda_o(),
      .sda_oe_n_o(sda_oe_n), .prox_event_i(ev_p), .light_event_i(ev_l),
      .cycle_end_i(ev_c), .osc_run_o(osc_run), .step_tick_o(tick),
      .wait_enable_o(wait_en), .prox_enable_o(prox_en),
      .light_enable_o(light_en), .light_steps_o(light_steps),
      .prox_steps_o(prox_steps), .light_max_count_o(max_count),
      .prox_irq_o(prox_irq), .light_irq_o(light_irq), .prox_clr_o(),
      .light_clr_o());
   snscmd_host host (.dev_scl_oe_n_i(scl_oe_n), .dev_sda_oe_n_i(sda_oe_n),
      .scl_o(scl), .sda_o(sda));
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge core_clk_i)
   begin
      cycles++;
      if (scl_oe_n === 1'b0)
         held = 1'b1;
      if (cycles == 95000)
      begin
         fails++;
         tally_and_finish();
      end
   end
   task automatic wr(input logic [7:0] adr, input logic [23:0] d,
                     input int n, input int want);
      int a;
      host.xfer(adr, d, n, a);
      `CHK(a, want)
   endtask
   task automatic ev(input logic p, input logic l, input logic c);
      @(negedge core_clk_i);
      {ev_p, ev_l, ev_c} = {p, l, c};
      @(negedge core_clk_i);
      {ev_p, ev_l, ev_c} = 3'h0;
      repeat (2) @(negedge core_clk_i);
   endtask
   // gap between ticks; stopped oscillator reads as both loops timing out
   task automatic t_tick(input logic on);
      int n;
      n = 0;
      while (tick !== 1'b1 && n < 3 * STEPS)
      begin
         @(negedge core_clk_i);
         n++;
      end
      n = 0;
      do
      begin
         @(negedge core_clk_i);
         n++;
      end while (tick !== 1'b1 && n < 3 * STEPS);
      `CHK(n, on ? STEPS : 3 * STEPS)
   endtask
   task automatic t_reset();
      `CHK({osc_run, wait_en, prox_en, light_en, prox_irq}, 5'h00)
      `CHK({light_steps, prox_steps, max_count}, 34'h020103ff)
      `CHK({scl_oe_n, sda_oe_n}, 2'h3)
      t_tick(1'b0);
   endtask
   task automatic t_enable();
      wr(8'h74, 24'h800f00, 2, 0);
      `CHK(osc_run, 1'b0)
      wr(WA, 24'h800b00, 2, 3);
      `CHK({osc_run, wait_en, prox_en, light_en}, 4'hd)
      wr(WA, 24'h800500, 2, 3);
      `CHK({osc_run, wait_en, prox_en, light_en}, 4'ha)
      t_tick(1'b1);
   endtask
   task automatic t_inc();
      wr(WA, 24'ha1c0f6, 3, 4);
      `CHK({light_steps, prox_steps, max_count}, 34'h0800affff)
      wr(WA, 24'h8100db, 3, 4);
      `CHK({light_steps, max_count}, 25'h02593ff)
      `CHK(prox_steps, 9'h00a)
      wr(WA, 24'h7f0000, 1, 2);
      `CHK({light_steps, max_count}, 25'h081ffff)
   endtask
   task automatic t_read();
      logic [23:0] got;
      int a;
      wr(WA, 24'h82ff00, 2, 3);
      `CHK(prox_steps, 9'h001)
      wr(WA, 24'ha00000, 1, 2);
      `CHK(held, 1'b0)
      host.rd(RA, 3, got, a);
      `CHK(a, 1)
      `CHK(got, 24'h057fff)
      `CHK(held, 1'b1)
   endtask
   task automatic t_irq();
      logic [7:0] code [4] = '{8'he0, 8'he5, 8'he6, 8'he7};
      logic [1:0] left [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
      ev(1'b1, 1'b1, 1'b0);
      `CHK({prox_irq, light_irq}, 2'h0)
      wr(WA, 24'h801100, 2, 3);
      ev(1'b1, 1'b1, 1'b0);
      `CHK({prox_irq, light_irq}, 2'h1)
      wr(WA, 24'h803100, 2, 3);
      for (int i = 0; i < 4; i++)
      begin
         ev(1'b1, 1'b1, 1'b0);
         wr(WA, {code[i], 16'h0}, 1, 2);
         `CHK({prox_irq, light_irq}, left[i])
      end
   endtask
   task automatic t_sleep();
      // end the cycle whose interrupts were raised with sleep still off
      ev(1'b0, 1'b0, 1'b1);
      wr(WA, 24'h807100, 2, 3);
      ev(1'b0, 1'b0, 1'b1);
      `CHK(osc_run, 1'b1)
      ev(1'b1, 1'b0, 1'b0);
      ev(1'b0, 1'b0, 1'b1);
      `CHK(osc_run, 1'b0)
      t_tick(1'b0);
   endtask
   initial
   begin
      // the link side needs several link edges inside reset
      repeat (80) @(negedge core_clk_i);
      rst_n_i = 1'b1;
      repeat (60) @(negedge core_clk_i);
      t_reset();
      t_enable();
      t_inc();
      t_read();
      t_irq();
      t_sleep();
      tally_and_finish();
   end
endmodule
